/* File: rftck_regs.vh */
// Constants for the transmitter configuration and keying block
`ifndef RFTCK_REGS_VH
`define RFTCK_REGS_VH
// Latch addresses
`define RFTCK_LAT_REF     2'b00
`define RFTCK_LAT_DIV     2'b01
`define RFTCK_LAT_MOD     2'b10
`define RFTCK_LAT_FUNC    2'b11
// Reference word fields
`define RFTCK_TRIM_LSB    2
`define RFTCK_TRIM_MSB    12
`define RFTCK_RDIV_LSB    13
`define RFTCK_RDIV_MSB    16
// Divider word fields
`define RFTCK_FRAC_LSB    2
`define RFTCK_FRAC_MSB    13
`define RFTCK_INT_LSB     14
`define RFTCK_INT_MSB     21
`define RFTCK_HALF_BIT    22
`define RFTCK_PRESC_BIT   23
// Modulation word fields
`define RFTCK_KSEL_LO     2
`define RFTCK_KSEL_HI     3
`define RFTCK_MARK_LSB    4
`define RFTCK_MARK_MSB    10
`define RFTCK_SPACE_LSB   11
`define RFTCK_SPACE_MSB   17
`define RFTCK_GEXP_LSB    18
`define RFTCK_GEXP_MSB    20
// Function word fields
`define RFTCK_OSC_BIT     2
`define RFTCK_AMP_BIT     3
`define RFTCK_DFAC_LSB    4
`define RFTCK_DFAC_MSB    10
`define RFTCK_IDX_LSB     11
`define RFTCK_IDX_MSB     17
`define RFTCK_MON_LSB     18
`define RFTCK_MON_MSB     21
// Keying modes {high, low}
`define RFTCK_KEY_FSK     2'b00
`define RFTCK_KEY_GFSK    2'b01
`define RFTCK_KEY_ASK     2'b10
`define RFTCK_KEY_OOK     2'b11
// APB byte offsets
`define RFTCK_A_REF       8'h00
`define RFTCK_A_DIV       8'h04
`define RFTCK_A_MOD       8'h08
`define RFTCK_A_FUNC      8'h0c
`define RFTCK_A_STAT      8'h10
`define RFTCK_A_CTRL      8'h14
`define RFTCK_CTRL_RST    2'b00
`endif

/* File: rftck_top.v */
// Transmitter configuration latches, keying logic and APB view
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "rftck_regs.vh"
// Pins are sampled by mclk, so every rising serial edge is found by
// comparing the second synchroniser stage with its previous level.
// The host must hold each serial level for at least two mclk
// cycles, otherwise an edge can be lost between samples.
// Keying, power and divider outputs are all registered, so they move
// one mclk after the latch or transmit bit that drives them.
// Only the field layout and the keying arithmetic are modelled;
// the analog loop itself stands outside this block.
module rftck_top #(
   parameter WORD_W = 24        // Serial word width
) (
   input  wire        mclk,
   input  wire        resetn,
   input  wire        chip_enable,
   input  wire        serial_clock,
   input  wire        serial_data,
   input  wire        load_strobe,
   input  wire        tx_bit_input,
   output reg         tx_bit_clock,
   output reg         monitor_output,
   output reg         osc_on_bit,
   output reg         amp_on_bit,
   output reg         pa_enable,
   output reg  [6:0]  pa_dac_level,
   output reg         half_band_select,
   output reg         prescaler_89,
   output reg  [22:0] n_divide_word,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output reg         pslverr
);

   // Scale a deviation by a filter weight of 0..4 quarters
   function [13:0] rftck_scale;
      input [10:0] dev;
      input [2:0]  w;
      reg   [13:0] p;
      begin
         // Product fits 14 bits: 1024 times 4 at most
         // Dropping two bits divides by four
         p = dev * w;
         rftck_scale = {2'b00, p[13:2]};
      end
   endfunction

   // Reset release through two flops
   // Assertion is immediate; release waits two edges so no flop
   // leaves reset on a different edge from its neighbours
   reg        rst_s1;
   reg        rst_n;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // Pin synchronisers; stage one feeds stage two only
   // Edge detectors start low, matching the idle level of both pins,
   // so no false edge follows reset
   reg  [4:0] pin_s1;            // First stage
   reg  [4:0] pin_s2;            // Second stage
   reg        sclk_d;            // Previous serial clock level
   reg        le_d;              // Previous strobe level
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= 5'h00;
         pin_s2 <= 5'h00;
         sclk_d <= 1'b0;
         le_d   <= 1'b0;
      end else begin
         pin_s1 <= {chip_enable, serial_clock, serial_data, load_strobe, tx_bit_input};
         pin_s2 <= pin_s1;
         sclk_d <= pin_s2[3];
         le_d   <= pin_s2[1];
      end
   end
   // Stage order: enable, clock, data, strobe, transmit bit
   wire ce_s    = pin_s2[4];
   wire sclk_up = pin_s2[3] & ~sclk_d;
   wire data_s  = pin_s2[2];
   wire le_up   = pin_s2[1] & ~le_d;
   wire txd_s   = pin_s2[0];

   // Latches are cleared, not held, while the chip is disabled
   // Shift register and the four latches
   reg  [WORD_W-1:0] shift_reg;  // Serial shift register
   reg  [WORD_W-1:0] lat_ref;    // Reference/trim word
   reg  [WORD_W-1:0] lat_div;    // Divider word
   reg  [WORD_W-1:0] lat_mod;    // Modulation word
   reg  [WORD_W-1:0] lat_func;   // Function word

   // Clearing on the synchronised enable costs two cycles of delay
   // but keeps the whole block on one clock and one reset
   // Serial load port; disabled chip holds everything cleared
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg <= {WORD_W{1'b0}};
         lat_ref   <= {WORD_W{1'b0}};
         lat_div   <= {WORD_W{1'b0}};
         lat_mod   <= {WORD_W{1'b0}};
         lat_func  <= {WORD_W{1'b0}};
      end else if (!ce_s) begin
         // Activity ignored, contents erased
         shift_reg <= {WORD_W{1'b0}};
         lat_ref   <= {WORD_W{1'b0}};
         lat_div   <= {WORD_W{1'b0}};
         lat_mod   <= {WORD_W{1'b0}};
         lat_func  <= {WORD_W{1'b0}};
      end else begin
         // MSB enters first; oldest bits fall off the top
         // Surplus leading bits simply fall off, so a host may send
         // padding ahead of each word
         if (sclk_up) begin
            shift_reg <= {shift_reg[WORD_W-2:0], data_s};
         end
         // Strobe edge copies the word into one latch
         if (le_up) begin
            case (shift_reg[1:0])
               `RFTCK_LAT_REF: begin
                  lat_ref <= shift_reg;
               end
               `RFTCK_LAT_DIV: begin
                  lat_div <= shift_reg;
               end
               `RFTCK_LAT_MOD: begin
                  lat_mod <= shift_reg;
               end
               // Default covers the function word address 2'b11
               default: begin
                  lat_func <= shift_reg;
               end
            endcase
         end
      end
   end

   // Field views
   // Each field is a fixed slice; nothing here is stored twice
   // Trim is signed; it is sign-extended where the divider word is formed
   wire [10:0] trim      = lat_ref[`RFTCK_TRIM_MSB:`RFTCK_TRIM_LSB];
   wire [3:0]  rdiv      = lat_ref[`RFTCK_RDIV_MSB:`RFTCK_RDIV_LSB];
   wire [11:0] frac      = lat_div[`RFTCK_FRAC_MSB:`RFTCK_FRAC_LSB];
   wire [7:0]  int_part  = lat_div[`RFTCK_INT_MSB:`RFTCK_INT_LSB];
   wire [1:0]  keying    = {lat_mod[`RFTCK_KSEL_HI], lat_mod[`RFTCK_KSEL_LO]};
   wire [6:0]  mark_pwr  = lat_mod[`RFTCK_MARK_MSB:`RFTCK_MARK_LSB];
   wire [6:0]  space_dev = lat_mod[`RFTCK_SPACE_MSB:`RFTCK_SPACE_LSB];
   wire [2:0]  gexp      = lat_mod[`RFTCK_GEXP_MSB:`RFTCK_GEXP_LSB];
   wire [6:0]  dfac      = lat_func[`RFTCK_DFAC_MSB:`RFTCK_DFAC_LSB];
   wire [6:0]  idx       = lat_func[`RFTCK_IDX_MSB:`RFTCK_IDX_LSB];
   wire [3:0]  mon_sel   = lat_func[`RFTCK_MON_MSB:`RFTCK_MON_LSB];

   // Software control register
   // With bit0 set the pin is ignored, so software can key the
   // transmitter without a host bit stream
   reg  [1:0]  ctrl;             // Bit0 soft data source, bit1 soft bit
   wire        tx_raw = ctrl[0] ? ctrl[1] : txd_s;

   // PFD rate pulse: mclk stands in for the reference, divided by R
   // A divide ratio of zero would stall the tick, so the compare
   // uses greater-or-equal and wraps at once
   reg  [3:0]  pfd_cnt;
   reg         pfd_tick;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pfd_cnt  <= 4'h0;
         pfd_tick <= 1'b0;
      end else if (pfd_cnt + 4'h1 >= rdiv) begin
         // R of zero is treated as one
         pfd_cnt  <= 4'h0;
         pfd_tick <= 1'b1;
      end else begin
         pfd_cnt  <= pfd_cnt + 4'h1;
         pfd_tick <= 1'b0;
      end
   end

   // Gaussian bit clock: factor times index PFD periods per bit
   // Factor or index of zero stops the clock instead of running
   // it at the PFD rate, which no host could follow
   // History is preloaded with the current bit so the filter
   // starts settled when Gaussian keying is chosen
   wire [13:0] bit_len = dfac * idx;
   wire [13:0] bit_half = {1'b0, bit_len[13:1]};
   reg  [13:0] bit_cnt;
   reg         bit_tick;         // One-cycle bit boundary
   reg  [2:0]  hist;             // Prefilter history, newest at 0
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt      <= 14'h0000;
         bit_tick     <= 1'b0;
         tx_bit_clock <= 1'b0;
         hist         <= 3'b000;
      end else if (keying != `RFTCK_KEY_GFSK || bit_len == 14'h0000) begin
         // Clock idles low outside Gaussian keying
         bit_cnt      <= 14'h0000;
         bit_tick     <= 1'b0;
         tx_bit_clock <= 1'b0;
         hist         <= {3{tx_raw}};
      end else begin
         bit_tick <= 1'b0;
         if (pfd_tick) begin
            if (bit_cnt + 14'h0001 >= bit_len) begin
               // Rising bit clock; host changes data after it
               bit_cnt      <= 14'h0000;
               bit_tick     <= 1'b1;
               tx_bit_clock <= 1'b1;
               hist         <= {hist[1:0], tx_raw};
            end else begin
               bit_cnt <= bit_cnt + 14'h0001;
               // Clock falls at half the bit period
               if (bit_cnt + 14'h0001 >= bit_half) begin
                  tx_bit_clock <= 1'b0;
               end
            end
         end
      end
   end

   // Filter weight 0..4: taps 1,2,1 smooth the frequency steps
   // Weights sum to four, so a steady bit gives the full deviation
   wire [2:0] gweight = {2'b00, hist[2]} + {1'b0, hist[1], 1'b0} + {2'b00, hist[0]};

   // Divider word: integer, fraction and trim, plus deviation
   // Fraction sits above three zero bits so that the trim field
   // lands on the least significant bits of the 15-bit fraction
   wire [22:0] centre = {int_part, frac, 3'b000}
                      + {{12{trim[10]}}, trim};
   // Deviation scaled by eight: 1/4096 steps in a 15-bit fraction
   wire [10:0] fsk_dev = {1'b0, space_dev, 3'b000};
   // Two to the exponent, in the same 1/4096 steps
   wire [10:0] gfsk_dev = {5'h00, 3'b001, 3'b000} << gexp;
   reg  [13:0] next_offset;
   // Only the two frequency keying modes move the divider;
   // amplitude modes keep the centre value
   always @* begin
      case (keying)
         `RFTCK_KEY_FSK: begin
            next_offset = tx_raw ? {3'b000, fsk_dev} : 14'h0000;
         end
         `RFTCK_KEY_GFSK: begin
            next_offset = rftck_scale(gfsk_dev, gweight);
         end
         default: begin
            next_offset = 14'h0000;
         end
      endcase
   end

   // Output power selection by keying mode
   // Defaults first so every path assigns both outputs
   reg  [6:0] next_level;
   reg        next_pa;
   always @* begin
      next_level = mark_pwr;
      next_pa    = lat_func[`RFTCK_AMP_BIT];
      case (keying)
         `RFTCK_KEY_ASK: begin
            next_level = tx_raw ? mark_pwr : space_dev;
         end
         `RFTCK_KEY_OOK: begin
            // Zero bit switches the stage off
            next_pa = lat_func[`RFTCK_AMP_BIT] & tx_raw;
         end
         default: begin
            next_level = mark_pwr;
         end
      endcase
   end

   // Registered analog-facing outputs
   // Registered so the analog side never sees decode glitches
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         osc_on_bit       <= 1'b0;
         amp_on_bit       <= 1'b0;
         pa_enable        <= 1'b0;
         pa_dac_level     <= 7'h00;
         half_band_select <= 1'b0;
         prescaler_89     <= 1'b0;
         // Divider word starts at zero with the latches
         n_divide_word    <= 23'h000000;
         monitor_output   <= 1'b0;
      end else begin
         osc_on_bit       <= lat_func[`RFTCK_OSC_BIT];
         amp_on_bit       <= lat_func[`RFTCK_AMP_BIT];
         pa_enable        <= next_pa;
         // Level forced to zero while the stage is off
         pa_dac_level     <= next_pa ? next_level : 7'h00;
         half_band_select <= lat_div[`RFTCK_HALF_BIT];
         prescaler_89     <= lat_div[`RFTCK_PRESC_BIT];
         n_divide_word    <= centre + {9'h000, next_offset};
         // Select zero shows regulator ready, the default
         case (mon_sel)
            4'h0: begin
               monitor_output <= ce_s;
            end
            4'h1: begin
               monitor_output <= tx_bit_clock;
            end
            // Unused monitor selects read low
            default: begin
               monitor_output <= 1'b0;
            end
         endcase
      end
   end

   // APB slave: zero wait states, error on unmapped address
   // Writes reach only the control register; the latches are
   // loaded through the serial port alone
   // Unaligned or unknown offsets answer with an error
   assign pready = 1'b1;
   wire       apb_acc = psel & penable;
   reg [31:0] next_rdata;
   reg        next_err;
   always @* begin
      // Defaults: no error, zero data
      next_err   = 1'b0;
      next_rdata = 32'h00000000;
      case (paddr)
         `RFTCK_A_REF: begin
            next_rdata = {8'h00, lat_ref};
         end
         `RFTCK_A_DIV: begin
            next_rdata = {8'h00, lat_div};
         end
         `RFTCK_A_MOD: begin
            next_rdata = {8'h00, lat_mod};
         end
         `RFTCK_A_FUNC: begin
            next_rdata = {8'h00, lat_func};
         end
         `RFTCK_A_STAT: begin
            // Live state: level, keying, bit, clock, enables
            next_rdata = {19'h00000, pa_dac_level, keying, tx_raw, tx_bit_clock, pa_enable, ce_s};
         end
         `RFTCK_A_CTRL: begin
            next_rdata = {30'h00000000, ctrl};
         end
         default: begin
            next_err = 1'b1;
         end
      endcase
   end

   // Read data and error are registered for the setup phase
   // Registering costs nothing since paddr is stable from setup
   // and the access phase samples it one edge later
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl    <= `RFTCK_CTRL_RST;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         if (apb_acc && pwrite && paddr == `RFTCK_A_CTRL) begin
            ctrl <= pwdata[1:0];
         end
         prdata  <= next_rdata;
         pslverr <= next_err;
      end
   end

endmodule

/* File: rftck_sva.sv */
// Port-level assertions for the transmitter configuration block
`timescale 1ns/100ps
module rftck_sva (
   input wire        mclk,
   input wire        resetn,
   input wire        chip_enable,
   input wire        load_strobe,
   input wire        psel,
   input wire        penable,
   input wire [7:0]  paddr,
   input wire        pready,
   input wire        pslverr,
   input wire        osc_on_bit,
   input wire        amp_on_bit,
   input wire        pa_enable,
   input wire [6:0]  pa_dac_level,
   input wire        half_band_select,
   input wire        prescaler_89,
   input wire [22:0] n_divide_word
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Chip held off long enough for the synchroniser and the clear
   sequence s_off;
      !chip_enable [*6];
   endsequence
   // Strobe pin seen high a few edges back, allowing for its synchroniser
   sequence s_strobed;
      $past(load_strobe, 4) || $past(load_strobe, 5) || $past(load_strobe, 6);
   endsequence
   property p_ready;
      pready;
   endproperty
   property p_unmap;
      psel && penable && $stable(paddr) && paddr[7:2] > 6'h05 |-> pslverr;
   endproperty
   property p_map;
      psel && penable && $stable(paddr) && paddr <= 8'h14 && paddr[1:0] == 2'b00 |-> !pslverr;
   endproperty
   property p_amp_off;
      !amp_on_bit |-> !pa_enable;
   endproperty
   property p_dac_off;
      !pa_enable |-> pa_dac_level == 7'h00;
   endproperty
   property p_clear;
      s_off |-> !osc_on_bit && !amp_on_bit && !half_band_select && !prescaler_89 && n_divide_word == 23'h0;
   endproperty
   property p_presc;
      $rose(prescaler_89) |-> s_strobed;
   endproperty
   property p_half;
      $rose(half_band_select) |-> s_strobed;
   endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   a_unmap: assert property (p_unmap) else $error("unmapped access without error");
   a_map: assert property (p_map) else $error("mapped access flagged");
   a_amp_off: assert property (p_amp_off) else $error("amplifier on while disabled");
   a_dac_off: assert property (p_dac_off) else $error("power code while stage off");
   a_clear: assert property (p_clear) else $error("latches not cleared");
   a_presc: assert property (p_presc) else $error("prescaler changed without strobe");
   a_half: assert property (p_half) else $error("half band changed without strobe");
endmodule
bind rftck_top rftck_sva u_sva (.mclk, .resetn, .chip_enable, .load_strobe, .psel, .penable, .paddr,
   .pready, .pslverr, .osc_on_bit, .amp_on_bit, .pa_enable, .pa_dac_level, .half_band_select,
   .prescaler_89, .n_divide_word);

/* File: rftck_host.sv */
// Host model driving the serial load port, chip enable and transmit bit
`timescale 1ns/100ps
module rftck_host (
   input  wire mclk,                // Pacing clock
   input  wire monitor_output,      // Regulator ready
   input  wire tx_bit_clock,        // Gaussian bit clock
   output reg  chip_enable = 1'b0,  // Chip enable pin
   output reg  serial_clock = 1'b0, // Idles low between words
   output reg  serial_data = 1'b0,  // Serial data
   output reg  load_strobe = 1'b0,  // Latch strobe
   output reg  tx_bit_input = 1'b0  // Transmit bit
);
   task automatic set_ce(input logic b);
      chip_enable <= b;
   endtask
   task automatic set_tx(input logic b);
      tx_bit_input <= b;
   endtask
   // Gaussian bits change only just after a rising bit clock
   task automatic gauss_bit(input logic b);
      @(posedge tx_bit_clock);
      @(posedge mclk);
      tx_bit_input <= b;
   endtask
   // Four surplus leading bits go out first; only the last 24 should count
   task automatic load(input logic [27:0] w);
      int i;
      for (i = 0; i < 200 && monitor_output !== 1'b1; i++) @(posedge mclk);
      for (i = 27; i >= 0; i--) begin
         serial_data <= w[i];
         repeat (4) @(posedge mclk);
         serial_clock <= 1'b1;
         repeat (4) @(posedge mclk);
         serial_clock <= 1'b0;
      end
      // Data no longer held, so show the other level
      serial_data <= ~w[0];
      repeat (4) @(posedge mclk);
      load_strobe <= 1'b1;
      repeat (8) @(posedge mclk);
      load_strobe <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
endmodule

/* File: rf_tx_config_and_keying_tb_top.sv */
// Self-checking bench for the transmitter configuration block
`timescale 1ns/100ps
`include "rftck_regs.vh"
module rf_tx_config_and_keying_tb_top;
   logic        mclk = 1'b0;    // 40 MHz clock
   logic        resetn = 1'b0;  // Reset, active low
   logic        psel = 1'b0;    // APB select
   logic        penable = 1'b0; // APB access phase
   logic        pwrite = 1'b0;  // APB direction
   logic [7:0]  paddr = 8'h00;  // APB address
   logic [31:0] pwdata = 32'h0; // APB write data
   logic [31:0] rd;             // Last read data
   logic        re;             // Last read error
   int          error_cnt = 0;  // Mismatches
   int          checked = 0;    // Comparisons
   int          cyc = 0;        // Hang guard
   wire chip_enable, serial_clock, serial_data, load_strobe, tx_bit_input, tx_bit_clock;
   wire monitor_output, osc_on_bit, amp_on_bit, pa_enable, half_band_select, prescaler_89;
   wire        pready, pslverr;
   wire [6:0]  pa_dac_level;
   wire [22:0] n_divide_word;
   wire [31:0] prdata;
   rftck_top u_dut (.*);
   rftck_host u_host (.*);
   always #12.5 mclk = ~mclk;
   // A hang counts as a failure
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask
   // One APB transfer; the access phase lasts until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic ld(input logic [23:0] w);
      u_host.load({4'h9, w});
   endtask
   // Reset values, read-only view, unmapped place
   task automatic t_regs;
      int i;
      for (i = 0; i < 4; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         check("latch", rd, 32'h0);
      end
      check("ready", monitor_output, 32'h1);
      apb(1'b1, `RFTCK_A_DIV, 32'hffffff);
      apb(1'b0, `RFTCK_A_DIV, 32'h0);
      check("ro", rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      check("unmap err", re, 32'h1);
      check("unmap dat", rd, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_func;
      ld(24'h000007);
      check("osc", osc_on_bit, 32'h1);
      check("pa", pa_enable, 32'h0);
      apb(1'b0, `RFTCK_A_FUNC, 32'h0);
      check("func", rd, 32'h7);
      ld(24'h00102b);
      check("osc", osc_on_bit, 32'h0);
      check("amp", amp_on_bit, 32'h1);
      $display("test func done");
   endtask
   // Trim of minus one pulls the fraction down by one
   task automatic t_div;
      ld(24'h003ffc);
      ld(24'hd6aaf1);
      check("ndiv", n_divide_word, {8'h5a, 12'habc, 3'h0} - 23'h1);
      check("half", half_band_select, 32'h1);
      check("presc", prescaler_89, 32'h1);
      ld(24'h16aaf1);
      check("half", half_band_select, 32'h0);
      check("presc", prescaler_89, 32'h0);
      $display("test div done");
   endtask
   // Keying modes against both transmit levels
   task automatic t_keys;
      int k, t, pe, n;
      logic pv;
      for (k = 0; k < 4; k++) begin
         if (k == 1) continue;
         ld(24'h015552 | 24'(k << 2));
         for (t = 0; t < 2; t++) begin
            u_host.set_tx(t[0]);
            repeat (8) @(posedge mclk);
            pe = (k == 3) ? t : 1;
            check("pa", pa_enable, pe);
            check("dac", pa_dac_level, (k == 2 && t == 0) ? 7'h2a : (pe ? 7'h55 : 7'h0));
            check("ndiv", n_divide_word, 23'h2d55df + ((k == 0 && t == 1) ? 23'h150 : 23'h0));
            check("bclk", tx_bit_clock, 32'h0);
         end
      end
      // Rate factor 2 and index 2 give four clocks a bit
      ld(24'h000006);
      n = 0;
      pv = tx_bit_clock;
      for (k = 0; k < 80; k++) begin
         @(negedge mclk);
         n += (tx_bit_clock === 1'b1 && pv === 1'b0);
         pv = tx_bit_clock;
      end
      @(posedge mclk);
      check("rate", (n >= 19 && n <= 21), 32'h1);
      // Exponent 2: deviation 4/4096, eight fraction steps each, 0x20
      ld(24'h080006);
      repeat (4) u_host.gauss_bit(1'b1);
      repeat (20) @(posedge mclk);
      check("gdev", n_divide_word, 23'h2d55df + 23'h20);
      repeat (4) u_host.gauss_bit(1'b0);
      repeat (20) @(posedge mclk);
      check("gdev", n_divide_word, 23'h2d55df);
      $display("test keys done");
   endtask
   task automatic t_ce;
      u_host.set_ce(1'b0);
      repeat (8) @(posedge mclk);
      check("amp", amp_on_bit, 32'h0);
      check("ndiv", n_divide_word, 32'h0);
      ld(24'h00000f);
      u_host.set_ce(1'b1);
      repeat (8) @(posedge mclk);
      check("osc", osc_on_bit, 32'h0);
      apb(1'b0, `RFTCK_A_REF, 32'h0);
      check("ref", rd, 32'h0);
      $display("test ce done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      u_host.set_ce(1'b1);
      repeat (8) @(posedge mclk);
      t_regs();
      t_func();
      t_div();
      t_keys();
      t_ce();
      report_and_stop();
   end
endmodule
